// [odsc_chan.v]
// One converter channel: input register, output register and buffer enable.
// Assumes decoded strobes from the command port, each one cycle wide; load_level is a level held as long as the load pin.
`timescale 1ns/1ns
`default_nettype none
`include "odsc_map.vh"
module odsc_chan #(
   parameter W = 8
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rstn,
   // Strobes
   input  wire         clr,
   input  wire         wr_in,
   input  wire         wr_out,
   input  wire         xfer,
   input  wire         load_level,
   input  wire         shdn_wr,
   input  wire         shdn_bit,
   input  wire         wake,
   input  wire [W-1:0] data,
   // State
   output reg  [W-1:0] in_q,
   output reg  [W-1:0] out_q,
   output reg          en_q
);
   reg [W-1:0] in_d;

   // Next input register value.
   always @* begin
      in_d = in_q;
      if (clr) begin
         in_d = `ODSC_RST_CODE;
      end else if (wr_in) begin
         in_d = data;
      end
   end

   // Registers; a high load_level makes the output follow the input register.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         in_q  <= `ODSC_RST_CODE;
         out_q <= `ODSC_RST_CODE;
         en_q  <= 1'b1;
      end else begin
         in_q <= in_d;
         if (clr) begin
            out_q <= `ODSC_RST_CODE;
         end else if (wr_out) begin
            out_q <= data;
         end else if (xfer || load_level) begin
            out_q <= in_d;
         end
         if (wake) begin
            en_q <= 1'b1;
         end else if (shdn_wr) begin
            en_q <= shdn_bit;
         end
      end
   end
endmodule // odsc_chan
`default_nettype wire

// [odsc_host.sv]
// Host serial port model: sends 16-bit frames and records the serial output.
// Assumes clk at 40 ns; four clk cycles make half a 320 ns serial clock.
`timescale 1ns/1ns
`default_nettype none
module odsc_host (
   // Clock
   input  wire logic        clk,
   // Serial pins
   output var  logic        sclk,
   output var  logic        cs_n,
   output var  logic        din,
   input  wire logic        dout,
   // Output bits seen in the last frame
   output var  logic [15:0] seen
);
   // Idle clock low, deselected.
   initial {sclk, cs_n, din, seen} = {3'h2, 16'h0000};
   task automatic half();
      repeat (4) @(negedge clk);
   endtask
   // Sixteen clocks per frame, MSB first; the bit launched at a fall is read just before
   // the next fall, since the design shows it several clk cycles after the pin edge.
   task automatic send(input logic [15:0] w);
      cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         din = w[i];
         half();
         sclk = 1'b1;
         half();
         if (i < 15) seen[i+1] = dout;
         sclk = 1'b0;
      end
      half();
      cs_n = 1'b1;
      din = ~din; // A released line must not keep its last level.
      half();
      seen[0] = dout;
   endtask
   // Clock edges while deselected, which must be ignored.
   task automatic idle();
      repeat (4) begin
         sclk = 1'b1;
         half();
         sclk = 1'b0;
         half();
      end
   endtask
endmodule // odsc_host
`default_nettype wire

// [odsc_map.vh]
// Constants for the octal converter serial command port.
// Assumes inclusion by bare name from the design files.
`ifndef ODSC_MAP_VH
`define ODSC_MAP_VH
// ----------------------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------------------
`define ODSC_WORD_BITS     16
`define ODSC_ADDR_MSB      13
`define ODSC_ADDR_LSB      11
`define ODSC_CMD_MSB       10
`define ODSC_CMD_LSB       8
`define ODSC_DATA_MSB      7
`define ODSC_DATA_LSB      0
// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define ODSC_CMD_NOP       3'h0
`define ODSC_CMD_CLEAR     3'h1
`define ODSC_CMD_SHDN      3'h2
`define ODSC_CMD_PHASE     3'h3
`define ODSC_CMD_LOAD_ALL  3'h4
`define ODSC_CMD_LOAD_IN   3'h5
`define ODSC_CMD_LOAD_BOTH 3'h6
`define ODSC_CMD_XFER      3'h7
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ODSC_RST_CODE      8'h00
`define ODSC_RST_ENABLE    8'hFF
`define ODSC_RST_PHASE     1'b0
`endif

// [odsc_sync.v]
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to clk; the output follows once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module odsc_sync #(
   parameter RST_VAL = 1'b0
) (
   // Clock and reset
   input  wire clk,
   input  wire rstn,
   // Pin and filtered level
   input  wire pin,
   output reg  level_q
);
   reg s1_q;
   reg s2_q;
   reg s3_q;

   // The first stage feeds only the second, to keep metastability contained.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_q    <= RST_VAL;
         s2_q    <= RST_VAL;
         s3_q    <= RST_VAL;
         level_q <= RST_VAL;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end
endmodule // odsc_sync
`default_nettype wire

// [odsc_top.v]
// Serial command port of an eight-channel 8-bit converter.
// Assumes the serial pins and load strobe are asynchronous to clk, which must be well faster than the
// serial clock so that every serial edge is seen.
`timescale 1ns/1ns
`default_nettype none
`include "odsc_map.vh"
module odsc_top #(
   parameter NCH = 8,
   parameter W   = 8
) (
   // Clock and reset
   input  wire             clk,
   input  wire             rstn,
   // Serial link pins
   input  wire             sclk,
   input  wire             cs_n,
   input  wire             din,
   output reg              dout,
   // Load strobe
   input  wire             load_strobe_n,
   // Channel codes, channel a in the low byte
   output reg  [NCH*W-1:0] chan_code,
   output reg  [NCH-1:0]   chan_enable,
   output reg              phase_rising
);
   // -------------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------------
   wire sclk_s;
   wire cs_n_s;
   wire din_s;
   wire ld_n_s;

   odsc_sync #(.RST_VAL(1'b0)) u_sclk (.clk(clk), .rstn(rstn), .pin(sclk), .level_q(sclk_s));
   odsc_sync #(.RST_VAL(1'b1)) u_cs   (.clk(clk), .rstn(rstn), .pin(cs_n), .level_q(cs_n_s));
   odsc_sync #(.RST_VAL(1'b0)) u_din  (.clk(clk), .rstn(rstn), .pin(din),  .level_q(din_s));
   odsc_sync #(.RST_VAL(1'b1)) u_ld   (.clk(clk), .rstn(rstn), .pin(load_strobe_n), .level_q(ld_n_s));

   // -------------------------------------------------------------------------
   // Edge detection
   // -------------------------------------------------------------------------
   reg  sclk_p_q;
   reg  cs_p_q;
   wire sclk_rise = sclk_s & ~sclk_p_q;
   wire sclk_fall = ~sclk_s & sclk_p_q;
   wire cs_rise   = cs_n_s & ~cs_p_q;

   // Previous filtered levels.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sclk_p_q <= 1'b0;
         cs_p_q   <= 1'b1;
      end else begin
         sclk_p_q <= sclk_s;
         cs_p_q   <= cs_n_s;
      end
   end

   // -------------------------------------------------------------------------
   // Shift register and serial output
   // -------------------------------------------------------------------------
   reg [`ODSC_WORD_BITS-1:0] shift_q;
   reg                       spill_q;
   reg                       phase_q;
   wire                      active = ~cs_n_s;

   // Bit 15 is the bit that entered sixteen edges ago; it leaves on the chosen edge.
   // The bit pushed out at a rise is kept so the falling mode can show it half a cycle later.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shift_q <= {`ODSC_WORD_BITS{1'b0}};
         spill_q <= 1'b0;
         dout    <= 1'b0;
      end else if (active) begin
         if (sclk_rise) begin
            shift_q <= {shift_q[`ODSC_WORD_BITS-2:0], din_s};
            spill_q <= shift_q[`ODSC_WORD_BITS-1];
            if (phase_q) begin
               dout <= shift_q[`ODSC_WORD_BITS-1];
            end
         end else if (sclk_fall && !phase_q) begin
            dout <= spill_q;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Command decode
   // -------------------------------------------------------------------------
   // The two top bits are never decoded; they only pass on to the serial output.
   wire [2:0]   addr = shift_q[`ODSC_ADDR_MSB:`ODSC_ADDR_LSB];
   wire [2:0]   cmd  = shift_q[`ODSC_CMD_MSB:`ODSC_CMD_LSB];
   wire [W-1:0] data = shift_q[`ODSC_DATA_MSB:`ODSC_DATA_LSB];
   wire         exec = cs_rise;

   // Command test, used for every strobe below.
   function is_cmd;
      input [2:0] c;
      input [2:0] code;
      begin
         is_cmd = (c == code);
      end
   endfunction

   // Code zero drives no strobe at all.
   wire do_clr  = exec & is_cmd(cmd, `ODSC_CMD_CLEAR);
   wire do_shdn = exec & is_cmd(cmd, `ODSC_CMD_SHDN);
   wire do_ph   = exec & is_cmd(cmd, `ODSC_CMD_PHASE);
   wire do_all  = exec & is_cmd(cmd, `ODSC_CMD_LOAD_ALL);
   wire do_in   = exec & is_cmd(cmd, `ODSC_CMD_LOAD_IN);
   wire do_both = exec & is_cmd(cmd, `ODSC_CMD_LOAD_BOTH);
   wire do_xfer = exec & (is_cmd(cmd, `ODSC_CMD_XFER) | is_cmd(cmd, `ODSC_CMD_PHASE));
   wire do_wake = do_clr | do_all | do_both;

   // Phase bit persists until reset or the opposite command.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phase_q <= `ODSC_RST_PHASE;
      end else if (do_ph) begin
         phase_q <= addr[2];
      end
   end

   // -------------------------------------------------------------------------
   // Channels
   // -------------------------------------------------------------------------
   wire [NCH*W-1:0] in_w;
   wire [NCH*W-1:0] out_w;
   wire [NCH-1:0]   en_w;

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_ch
         localparam [2:0] CH = g;
         wire sel = (addr == CH);
         odsc_chan #(.W(W)) u_ch (
            .clk        (clk),
            .rstn       (rstn),
            .clr        (do_clr),
            .wr_in      (do_all | ((do_in | do_both) & sel)),
            .wr_out     (do_all | (do_both & sel)),
            .xfer       (do_xfer),
            .load_level (~ld_n_s),
            .shdn_wr    (do_shdn),
            .shdn_bit   (data[g]),
            .wake       (do_wake),
            .data       (data),
            .in_q       (in_w[g*W +: W]),
            .out_q      (out_w[g*W +: W]),
            .en_q       (en_w[g])
         );
      end
   endgenerate

   // Registered copies so every output comes straight from a flip-flop.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         chan_code    <= {NCH*W{1'b0}};
         chan_enable  <= {NCH{1'b1}};
         phase_rising <= 1'b0;
      end else begin
         chan_code    <= out_w;
         chan_enable  <= en_w;
         phase_rising <= phase_q;
      end
   end
endmodule // odsc_top
`default_nettype wire

// [odsc_top_props.sv]
// Checker for the octal converter serial command port.
// Assumes it sees only the ports of odsc_top, all in the clk domain.
`timescale 1ns/1ns
`default_nettype none
module odsc_top_props #(
   parameter NCH = 8,
   parameter W   = 8
) (
   // Clock and reset
   input wire logic             clk,
   input wire logic             rstn,
   // Serial pins and strobe
   input wire logic             sclk,
   input wire logic             cs_n,
   input wire logic             din,
   input wire logic             dout,
   input wire logic             load_strobe_n,
   // Channel state
   input wire logic [NCH*W-1:0] chan_code,
   input wire logic [NCH-1:0]   chan_enable,
   input wire logic             phase_rising
);
   logic [3:0] cs_c, ld_c, fa_c, ri_c;
   logic       cs_p, sk_p;
   function automatic logic [3:0] age(input logic ev, input logic [3:0] c);
      return ev ? 4'h0 : (c == 4'hF ? c : c + 4'h1);
   endfunction
   // Saturating ages of pin events; every output change must follow a cause closely.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {cs_c, ld_c, fa_c, ri_c} <= 16'hFFFF;
         {cs_p, sk_p} <= 2'h2;
      end else begin
         {cs_p, sk_p} <= {cs_n, sclk};
         cs_c <= age(cs_n && !cs_p, cs_c);
         ld_c <= age(!load_strobe_n, ld_c);
         fa_c <= age(sk_p && !sclk, fa_c);
         ri_c <= age(sclk && !sk_p, ri_c);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   reset_state_a: assert property ($rose(rstn) |-> chan_code == '0 && chan_enable == '1 && !phase_rising)
      else $error("state after reset wrong");
   code_cause_a: assert property ($changed(chan_code) |-> cs_c < 4'hA || ld_c < 4'hA)
      else $error("channel code changed without cause");
   code_quiet_a: assert property (!cs_n && cs_c == 4'hF && ld_c == 4'hF |-> $stable(chan_code))
      else $error("channel code changed while shifting");
   enable_cause_a: assert property ($changed(chan_enable) |-> cs_c < 4'hA)
      else $error("enable changed without command");
   phase_cause_a: assert property ($changed(phase_rising) |-> cs_c < 4'hA)
      else $error("phase changed without command");
   dout_hold_a: assert property (cs_n && cs_c > 4'h9 |-> $stable(dout))
      else $error("serial output moved while deselected");
   dout_fall_a: assert property ($changed(dout) && !phase_rising |-> fa_c < 4'h8)
      else $error("serial output moved off a falling edge");
   dout_rise_a: assert property ($changed(dout) && phase_rising |-> ri_c < 4'h8)
      else $error("serial output moved off a rising edge");
   cover property ($rose(phase_rising));
   cover property ($changed(chan_enable));
   cover property (!load_strobe_n && $changed(chan_code));
endmodule // odsc_top_props
bind odsc_top odsc_top_props #(.NCH(NCH), .W(W)) odsc_top_props_inst (.clk(clk), .rstn(rstn), .sclk(sclk),
   .cs_n(cs_n), .din(din), .dout(dout), .load_strobe_n(load_strobe_n), .chan_code(chan_code),
   .chan_enable(chan_enable), .phase_rising(phase_rising));
`default_nettype wire

// [odsc_top_tb.sv]
// Testbench for odsc_top with a host model and a queue of expected states.
// Assumes odsc_host and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module odsc_top_tb;
   logic             clk = 1'b0;
   logic             rstn = 1'b0;
   logic             load_strobe_n = 1'b1;
   wire logic        sclk, cs_n, din, dout, phase_rising;
   wire logic [63:0] chan_code;
   wire logic [7:0]  chan_enable;
   wire logic [15:0] seen;
   logic [63:0]      in_m = 64'h0, out_m = 64'h0;
   logic [7:0]       en = 8'hFF;
   logic             ph = 1'b0, pl = 1'b0;
   logic [15:0]      prev = 16'h0000;
   logic [89:0]      q[$];
   event             ev;
   int               failures = 0, checks_done = 0, cyc = 0;
   odsc_top odsc_top_inst (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
      .load_strobe_n(load_strobe_n), .chan_code(chan_code), .chan_enable(chan_enable), .phase_rising(phase_rising));
   odsc_host odsc_host_inst (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .seen(seen));
   always #20 clk = ~clk;
   task automatic final_report();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // A hang is cut short well past the expected run length.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         failures++;
         final_report();
      end
   end
   task automatic cmp(input string s, input logic [63:0] e, input logic [63:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic note(input logic [89:0] n);
      q.push_back(n);
      -> ev;
      repeat (12) @(negedge clk);
   endtask
   // Sends one word and updates the expected state.
   task automatic frame(input logic [15:0] w);
      logic [7:0] d;
      logic [2:0] a;
      logic       chk;
      d = w[7:0];
      a = w[13:11];
      chk = !ph && !pl; // Output bits are only predicted in falling mode.
      pl = ph;
      odsc_host_inst.send(w);
      case (w[10:8])
         3'h1: {in_m, out_m, en} = {128'h0, 8'hFF};
         3'h2: en = d;
         3'h3: {ph, out_m} = {a[2], in_m};
         3'h4: {in_m, out_m, en} = {{16{d}}, 8'hFF};
         3'h5: in_m[a*8+:8] = d;
         3'h6: {in_m[a*8+:8], out_m[a*8+:8], en} = {d, d, 8'hFF};
         3'h7: out_m = in_m;
         default: ;
      endcase
      if (!load_strobe_n) out_m = in_m;
      note({chk, prev, ph, en, out_m});
      prev = w;
   endtask
   // Watches the outputs once each noted result has had time to settle.
   initial forever begin
      logic [89:0] n;
      @ev;
      repeat (10) @(negedge clk);
      n = q.pop_front();
      cmp("chan_code", n[63:0], chan_code);
      cmp("chan_enable", 64'(n[71:64]), 64'(chan_enable));
      cmp("phase_rising", 64'(n[72]), 64'(phase_rising));
      if (n[89]) cmp("dout", 64'(n[88:73]), 64'(seen));
   end
   initial begin
      void'($urandom(32'hC07D91F4));
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      repeat (8) @(negedge clk);
      note({1'b0, prev, ph, en, out_m});
      for (int i = 0; i < 8; i++) frame({2'b11, i[2:0], 3'h5, 8'($urandom)});
      frame({8'h85, 8'($urandom)});
      frame(16'h0700);
      frame({8'h1E, 8'($urandom)});
      frame({8'h02, 8'($urandom)});
      frame({8'h36, 8'($urandom)});
      frame(16'h0200);
      frame({8'h04, 8'($urandom)});
      frame({8'h0D, 8'($urandom)});
      frame({8'h23, 8'($urandom)});
      frame({8'h2D, 8'($urandom)});
      frame(16'h0300);
      frame(16'h0000);
      frame(16'h0100);
      odsc_host_inst.idle();
      frame({8'h15, 8'($urandom)});
      load_strobe_n = 1'b0;
      out_m = in_m;
      note({1'b0, prev, ph, en, out_m});
      frame({8'h3D, 8'($urandom)});
      load_strobe_n = 1'b1;
      frame({8'h2D, 8'($urandom)});
      frame(16'h0000);
      final_report();
   end
endmodule // odsc_top_tb
`default_nettype wire
